// ==== logic/fmc_pkg.sv ====
package fmc_pkg;

  // register offsets on the management bus
  localparam logic [7:0] OFS_CFG_ONE  = 8'h00;
  localparam logic [7:0] OFS_CFG_TWO  = 8'h01;
  localparam logic [7:0] OFS_STAT_ONE = 8'h02;

  // power-up values
  localparam logic [7:0] RST_CFG_ONE  = 8'h90;
  localparam logic [7:0] RST_CFG_TWO  = 8'h7f;
  localparam logic [7:0] RST_STAT_ONE = 8'h00;

  // value read back from an unmapped offset
  localparam logic [7:0] RD_UNMAPPED  = 8'h00;

  // status bits that a status read does not clear
  localparam logic [7:0] STAT_KEEP_MASK = 8'h20;

  // configuration one fields
  localparam int C1_MONITOR   = 0;
  localparam int C1_ALERT_EN  = 1;
  localparam int C1_SENSE_SEL = 2;
  localparam int C1_PWM_INV   = 3;
  localparam int C1_FAIL_EN   = 4;
  localparam int C1_MODE_LO   = 5;
  localparam int C1_MODE_HI   = 6;
  localparam int C1_CTRL_SRC  = 7;

  // configuration two fields
  localparam int C2_PWM_EN0   = 0;
  localparam int C2_TACH_EN0  = 2;
  localparam int C2_LOC_IE    = 4;
  localparam int C2_R1_IE     = 5;
  localparam int C2_R2_IE     = 6;
  localparam int C2_SOFT_RST  = 7;

  // status one fields
  localparam int S1_ALARM1    = 0;
  localparam int S1_FAULT1    = 1;
  localparam int S1_R1_HIGH   = 2;
  localparam int S1_R1_LOW    = 3;
  localparam int S1_R1_OVER   = 4;
  localparam int S1_DIODE1    = 5;
  localparam int S1_L_HIGH    = 6;
  localparam int S1_L_LOW     = 7;

  // seven-bit bus address of this device
  localparam logic [6:0] SMB_DEV_ADDR = 7'h2c;

  // source-to-fan mapping codes
  typedef enum logic [1:0] {
    MODE_SPLIT   = 2'h0,
    MODE_R1_BOTH = 2'h1,
    MODE_R2_BOTH = 2'h2,
    MODE_MAX     = 2'h3
  } fmc_mode_t;

  // bus slave states, gray along the usual path
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h3,
    ST_CMD       = 4'h2,
    ST_CMD_ACK   = 4'h6,
    ST_WDATA     = 4'h7,
    ST_WDATA_ACK = 4'h5,
    ST_RDATA     = 4'h4,
    ST_RACK      = 4'hc
  } fmc_smb_state_t;

  // per-cycle monitoring results
  typedef struct packed {
    logic fan1_alarm;
    logic fan1_fault;
    logic r1_high;
    logic r1_low;
    logic r1_over;
    logic l_high;
    logic l_low;
  } fmc_cond_t;

  // temperature readings, two's complement
  typedef struct packed {
    logic [7:0] loc;
    logic [7:0] rem1;
    logic [7:0] rem2;
  } fmc_temps_t;

endpackage

// ==== logic/fmc_smb_slave.sv ====
module fmc_smb_slave
  import fmc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // bus pins
  input  wire logic       scl_pin,
  input  wire logic       sda_pin,
  output logic            sda_oe,
  // register side
  output logic            wr_stb,
  output logic            rd_req,
  output logic [7:0]      reg_addr,
  output logic [7:0]      wr_data,
  input  wire logic [7:0] rd_data
);

  logic [1:0]     scl_s;      // scl synchroniser
  logic [1:0]     sda_s;      // sda synchroniser
  logic           scl_d;      // delayed scl for edges
  logic           sda_d;      // delayed sda for edges
  fmc_smb_state_t state_reg;  // protocol state
  logic [3:0]     cnt_reg;    // bit counter
  logic [7:0]     shift_reg;  // byte shifter
  logic [7:0]     ptr_reg;    // register pointer
  logic [7:0]     wdat_reg;   // written byte
  logic           rw_reg;     // read direction
  logic           more_reg;   // master acked a read byte
  logic           oe_reg;     // sda pulled low
  logic           wr_reg;     // write strobe

  // pin synchronisers and edge history
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], scl_pin};
      sda_s <= {sda_s[0], sda_pin};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
    end
  end

  // bus events
  wire scl_rise = scl_s[1] & ~scl_d;
  wire scl_fall = ~scl_s[1] & scl_d;
  wire start_c  = scl_s[1] & scl_d & sda_d & ~sda_s[1];
  wire stop_c   = scl_s[1] & scl_d & ~sda_d & sda_s[1];
  wire byte_end = scl_fall & (cnt_reg == 4'h8);
  wire addr_hit = (shift_reg[7:1] == SMB_DEV_ADDR);

  // read data is fetched as the first bit goes out
  assign rd_req = ~start_c & ~stop_c & scl_fall &
                  (((state_reg == ST_ADDR_ACK) & rw_reg) |
                   ((state_reg == ST_RACK) & more_reg));

  // protocol engine
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg   <= 8'h00;
      wdat_reg  <= 8'h00;
      rw_reg    <= 1'b0;
      more_reg  <= 1'b0;
      oe_reg    <= 1'b0;
      wr_reg    <= 1'b0;
    end else begin
      wr_reg <= 1'b0;
      if (start_c) begin
        // start or repeated start
        state_reg <= ST_ADDR;
        cnt_reg   <= 4'h0;
        oe_reg    <= 1'b0;
      end else if (stop_c) begin
        state_reg <= ST_IDLE;
        oe_reg    <= 1'b0;
      end else begin
        case (state_reg)
          ST_ADDR, ST_CMD, ST_WDATA: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s[1]};
              cnt_reg   <= 4'(cnt_reg + 4'h1);
            end else if (byte_end) begin
              cnt_reg <= 4'h0;
              if (state_reg == ST_ADDR) begin
                // answer only our own address
                state_reg <= addr_hit ? ST_ADDR_ACK : ST_IDLE;
                oe_reg    <= addr_hit;
                rw_reg    <= shift_reg[0];
              end else if (state_reg == ST_CMD) begin
                ptr_reg   <= shift_reg;
                state_reg <= ST_CMD_ACK;
                oe_reg    <= 1'b1;
              end else begin
                wdat_reg  <= shift_reg;
                wr_reg    <= 1'b1;
                state_reg <= ST_WDATA_ACK;
                oe_reg    <= 1'b1;
              end
            end
          end
          ST_ADDR_ACK, ST_CMD_ACK, ST_WDATA_ACK: begin
            if (scl_fall) begin
              if (rd_req) begin
                state_reg <= ST_RDATA;
                shift_reg <= rd_data;
                oe_reg    <= ~rd_data[7];
              end else begin
                state_reg <= (state_reg == ST_ADDR_ACK) ? ST_CMD
                                                        : ST_WDATA;
                oe_reg    <= 1'b0;
              end
            end
          end
          ST_RDATA: begin
            if (scl_rise) begin
              cnt_reg <= 4'(cnt_reg + 4'h1);
            end else if (byte_end) begin
              state_reg <= ST_RACK;
              cnt_reg   <= 4'h0;
              oe_reg    <= 1'b0;
            end else if (scl_fall) begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              oe_reg    <= ~shift_reg[6];
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              more_reg <= ~sda_s[1];
            end else if (scl_fall) begin
              state_reg <= more_reg ? ST_RDATA : ST_IDLE;
              shift_reg <= rd_data;
              oe_reg    <= more_reg & ~rd_data[7];
            end
          end
          default: begin
            oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // register side outputs
  assign sda_oe   = oe_reg;
  assign wr_stb   = wr_reg;
  assign wr_data  = wdat_reg;
  assign reg_addr = ptr_reg;

endmodule

// ==== logic/fmc_regs.sv ====
module fmc_regs
  import fmc_pkg::*;
(
  // clock and reset
  input  wire logic       MCLK,
  input  wire logic       RST_N,
  // management bus pins
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  // results from measurement logic
  input  wire logic       MON_CYCLE_DONE,
  input  wire fmc_cond_t  COND_IN,
  input  wire logic       FAN2_FAULT_IN,
  input  wire logic       DIODE_CHECK_DONE,
  input  wire logic [1:0] DIODE_FAULT_IN,
  input  wire fmc_temps_t TEMPS_IN,
  // fan pins
  input  wire logic [1:0] PWM_RAW_IN,
  output logic [1:0]      PWM_PIN_OUT,
  input  wire logic [1:0] TACH_PIN_IN,
  // controls to measurement and fan logic
  output logic [1:0]      TACH_PULSE_OUT,
  output logic            MONITOR_EN_OUT,
  output logic            SENSE_ANALOG_OUT,
  output logic            AUTO_CTRL_OUT,
  output logic            SW_DUTY_OUT,
  output logic            SW_RPM_OUT,
  output logic [7:0]      FAN1_SRC_TEMP_OUT,
  output logic [7:0]      FAN2_SRC_TEMP_OUT,
  output logic            SOFT_RESET_OUT,
  // alarm pins
  output logic            ALERT_OUT_N,
  output logic            FAN_FAIL_OUT_N
);

  // bus slave wires
  logic       wr_stb;       // one-cycle write strobe
  logic       rd_req;       // one-cycle read fetch
  logic [7:0] reg_addr;     // register pointer
  logic [7:0] wr_data;      // written byte
  logic [7:0] rd_data;      // byte for the slave

  // register state
  logic [7:0] cfg_one_reg;  // configuration one
  logic [7:0] cfg_one_next;
  logic [6:0] cfg_two_reg;  // configuration two, low bits
  logic [6:0] cfg_two_next;
  logic       srst_reg;     // soft reset pulse
  logic       srst_next;
  logic [7:0] stat_reg;     // status one
  logic [7:0] stat_next;
  logic       hold_reg;     // alarm speed already reported
  logic       hold_next;

  // pin side state
  logic [1:0] pwm_reg;      // driven pwm pins
  logic [1:0] tach_reg;     // gated tach pulses
  logic [1:0] tach_m;       // first sync stage
  logic [1:0] tach_s;       // second sync stage
  logic [7:0] src1_reg;     // fan one source temperature
  logic [7:0] src2_reg;     // fan two source temperature
  logic       alert_reg;    // alert asserted
  logic       fail_reg;     // fan failure asserted

  // register bus slave
  fmc_smb_slave u_slave (
    .clk      (MCLK),
    .rst_n    (RST_N),
    .scl_pin  (SCL_IN),
    .sda_pin  (SDA_IN),
    .sda_oe   (SDA_OE),
    .wr_stb   (wr_stb),
    .rd_req   (rd_req),
    .reg_addr (reg_addr),
    .wr_data  (wr_data),
    .rd_data  (rd_data)
  );

  // open-drain data pin only ever pulls low
  assign SDA_OUT = 1'b0;

  // soft reset also returns every register outside the bus slave to power-up
  wire rst_any = ~RST_N | srst_reg;

  // address decode
  wire hit_one  = (reg_addr == OFS_CFG_ONE);
  wire hit_two  = (reg_addr == OFS_CFG_TWO);
  wire hit_stat = (reg_addr == OFS_STAT_ONE);
  wire wr_one   = wr_stb & hit_one;
  wire wr_two   = wr_stb & hit_two;
  wire rd_stat  = rd_req & hit_stat;

  // read mux, soft reset bit always reads zero
  assign rd_data = hit_one  ? cfg_one_reg :
                   hit_two  ? {1'b0, cfg_two_reg} :
                   hit_stat ? stat_reg :
                   RD_UNMAPPED;

  // configuration fields
  wire       mon_en   = cfg_one_reg[C1_MONITOR];
  wire       alert_en = cfg_one_reg[C1_ALERT_EN];
  wire       analog   = cfg_one_reg[C1_SENSE_SEL];
  wire       pwm_inv  = cfg_one_reg[C1_PWM_INV];
  wire       fail_en  = cfg_one_reg[C1_FAIL_EN];
  wire       auto_on  = cfg_one_reg[C1_CTRL_SRC];
  wire [1:0] mode     = cfg_one_reg[C1_MODE_HI:C1_MODE_LO];
  wire       loc_ie   = cfg_two_reg[C2_LOC_IE];
  wire       r1_ie    = cfg_two_reg[C2_R1_IE];

  // only cycles with monitoring on update flags other than the diode flag
  wire cyc = MON_CYCLE_DONE & mon_en;

  // power-up diode check result
  wire d1_bad = DIODE_CHECK_DONE & DIODE_FAULT_IN[0];
  wire d2_bad = DIODE_CHECK_DONE & DIODE_FAULT_IN[1];

  // configuration one next value
  assign cfg_one_next = wr_one ? wr_data : cfg_one_reg;

  // configuration two next value, check fault clears win
  always_comb begin
    cfg_two_next = wr_two ? wr_data[6:0] : cfg_two_reg;
    if (d1_bad) begin
      cfg_two_next[C2_R1_IE] = 1'b0;
    end
    if (d2_bad) begin
      cfg_two_next[C2_R2_IE] = 1'b0;
    end
  end

  // writing a one to the top bit fires one reset cycle
  assign srst_next = wr_two & wr_data[C2_SOFT_RST] & ~srst_reg;

  // status set terms for this cycle
  logic [7:0] stat_set;
  always_comb begin
    stat_set = 8'h00;
    // alarm speed suppressed once reported
    stat_set[S1_ALARM1]  = cyc & COND_IN.fan1_alarm & ~hold_reg;
    // stall or underspeed
    stat_set[S1_FAULT1]  = cyc & COND_IN.fan1_fault;
    // remote one limit crossings, re-set each cycle
    stat_set[S1_R1_HIGH] = cyc & COND_IN.r1_high;
    stat_set[S1_R1_LOW]  = cyc & COND_IN.r1_low;
    // overheat threshold crossing
    stat_set[S1_R1_OVER] = cyc & COND_IN.r1_over;
    // diode fault, only from the power-up check
    stat_set[S1_DIODE1]  = d1_bad;
    // local limit crossings, re-set each cycle
    stat_set[S1_L_HIGH]  = cyc & COND_IN.l_high;
    stat_set[S1_L_LOW]   = cyc & COND_IN.l_low;
  end

  // a status read clears all but the diode flag
  wire [7:0] stat_clr = rd_stat ? ~STAT_KEEP_MASK : 8'h00;

  // set wins over a read clear in the same cycle
  assign stat_next = (stat_reg & ~stat_clr) | stat_set;

  // hold arms on a read of a set alarm, drops when alarm ends
  assign hold_next = (hold_reg & ~(cyc & ~COND_IN.fan1_alarm)) |
                     (rd_stat & stat_reg[S1_ALARM1]);

  // register bank
  always_ff @(posedge MCLK) begin
    if (rst_any) begin
      cfg_one_reg <= RST_CFG_ONE;
      cfg_two_reg <= RST_CFG_TWO[6:0];
      stat_reg    <= RST_STAT_ONE;
      hold_reg    <= 1'b0;
    end else begin
      cfg_one_reg <= cfg_one_next;
      cfg_two_reg <= cfg_two_next;
      stat_reg    <= stat_next;
      hold_reg    <= hold_next;
    end
  end

  // soft reset pulse, cleared by its own reset cycle
  always_ff @(posedge MCLK) begin
    if (rst_any) begin
      srst_reg <= 1'b0;
    end else begin
      srst_reg <= srst_next;
    end
  end

  // per-fan pin logic
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_fan
      // enabled pwm, inverted on request, low when off
      wire pwm_d = cfg_two_reg[C2_PWM_EN0 + i] &
                   (PWM_RAW_IN[i] ^ pwm_inv);
      // tach pulses pass only when measuring digitally
      wire tach_d = tach_s[i] & cfg_two_reg[C2_TACH_EN0 + i] &
                    mon_en & ~analog;
      // tach pin synchroniser and output registers
      always_ff @(posedge MCLK) begin
        if (rst_any) begin
          tach_m[i]   <= 1'b0;
          tach_s[i]   <= 1'b0;
          tach_reg[i] <= 1'b0;
          pwm_reg[i]  <= 1'b0;
        end else begin
          tach_m[i]   <= TACH_PIN_IN[i];
          tach_s[i]   <= tach_m[i];
          tach_reg[i] <= tach_d;
          pwm_reg[i]  <= pwm_d;
        end
      end
    end
  endgenerate

  // hottest of the three channels, signed compare
  wire [7:0] hot_r = ($signed(TEMPS_IN.rem1) > $signed(TEMPS_IN.rem2))
                     ? TEMPS_IN.rem1 : TEMPS_IN.rem2;
  wire [7:0] hot_a = ($signed(TEMPS_IN.loc) > $signed(hot_r))
                     ? TEMPS_IN.loc : hot_r;

  // source selection per mapping code
  logic [7:0] src1_d;
  logic [7:0] src2_d;
  always_comb begin
    case (fmc_mode_t'(mode))
      MODE_SPLIT: begin
        src1_d = TEMPS_IN.rem1;
        src2_d = TEMPS_IN.rem2;
      end
      MODE_R1_BOTH: begin
        src1_d = TEMPS_IN.rem1;
        src2_d = TEMPS_IN.rem1;
      end
      MODE_R2_BOTH: begin
        src1_d = TEMPS_IN.rem2;
        src2_d = TEMPS_IN.rem2;
      end
      default: begin
        src1_d = hot_a;
        src2_d = hot_a;
      end
    endcase
  end

  // pending flags per interrupt channel
  wire fan_pend = (stat_reg[S1_ALARM1] | stat_reg[S1_FAULT1]) &
                  cfg_two_reg[C2_TACH_EN0];
  wire r1_pend  = r1_ie & (stat_reg[S1_R1_HIGH] | stat_reg[S1_R1_LOW] |
                           stat_reg[S1_R1_OVER] | stat_reg[S1_DIODE1]);
  wire loc_pend = loc_ie & (stat_reg[S1_L_HIGH] | stat_reg[S1_L_LOW]);
  wire alert_d  = alert_en & (fan_pend | r1_pend | loc_pend);

  // fan failure pin follows either fan fault
  wire fail_d = fail_en & (stat_reg[S1_FAULT1] | FAN2_FAULT_IN);

  // output registers for temperatures and alarms
  always_ff @(posedge MCLK) begin
    if (rst_any) begin
      src1_reg  <= 8'h00;
      src2_reg  <= 8'h00;
      alert_reg <= 1'b0;
      fail_reg  <= 1'b0;
    end else begin
      src1_reg  <= src1_d;
      src2_reg  <= src2_d;
      alert_reg <= alert_d;
      fail_reg  <= fail_d;
    end
  end

  // control outputs straight from configuration bits, soft reset from its pulse register
  assign MONITOR_EN_OUT    = mon_en;
  assign SENSE_ANALOG_OUT  = analog;
  assign AUTO_CTRL_OUT     = auto_on;
  assign SW_DUTY_OUT       = ~auto_on & (mode == MODE_SPLIT);
  assign SW_RPM_OUT        = ~auto_on & (mode == MODE_MAX);
  assign SOFT_RESET_OUT    = srst_reg;

  // pin outputs
  assign PWM_PIN_OUT       = pwm_reg;
  assign TACH_PULSE_OUT    = tach_reg;
  assign FAN1_SRC_TEMP_OUT = src1_reg;
  assign FAN2_SRC_TEMP_OUT = src2_reg;
  assign ALERT_OUT_N       = ~alert_reg;
  assign FAN_FAIL_OUT_N    = ~fail_reg;

endmodule

// ==== test/fmc_regs_chk.sv ====
module fmc_regs_chk
  import fmc_pkg::*;
(
  // clock and reset
  input  wire logic       MCLK,
  input  wire logic       RST_N,
  // bus pins
  input  wire logic       SCL_IN,
  input  wire logic       SDA_OUT,
  input  wire logic       SDA_OE,
  // measurement side
  input  wire fmc_temps_t TEMPS_IN,
  input  wire logic [1:0] TACH_PIN_IN,
  input  wire logic [1:0] TACH_PULSE_OUT,
  // control outputs
  input  wire logic       MONITOR_EN_OUT,
  input  wire logic       SENSE_ANALOG_OUT,
  input  wire logic       AUTO_CTRL_OUT,
  input  wire logic       SW_DUTY_OUT,
  input  wire logic       SW_RPM_OUT,
  input  wire logic [7:0] FAN1_SRC_TEMP_OUT,
  input  wire logic [7:0] FAN2_SRC_TEMP_OUT,
  input  wire logic       SOFT_RESET_OUT,
  input  wire logic       ALERT_OUT_N
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  // hottest reading, signed compare
  logic [7:0] lr;
  logic [7:0] hot;
  assign lr  = ($signed(TEMPS_IN.loc) > $signed(TEMPS_IN.rem1)) ?
               TEMPS_IN.loc : TEMPS_IN.rem1;
  assign hot = ($signed(lr) > $signed(TEMPS_IN.rem2)) ? lr : TEMPS_IN.rem2;

  tach_one_a: assert property (
    TACH_PULSE_OUT[0] |-> $past(TACH_PIN_IN[0], 3) &&
    $past(MONITOR_EN_OUT) && !$past(SENSE_ANALOG_OUT))
    else $error("tach pulse one without an enabled pin");
  tach_two_a: assert property (
    TACH_PULSE_OUT[1] |-> $past(TACH_PIN_IN[1], 3) &&
    $past(MONITOR_EN_OUT) && !$past(SENSE_ANALOG_OUT))
    else $error("tach pulse two without an enabled pin");
  // a soft reset clears the source registers for one cycle
  src_one_a: assert property (
    $past(RST_N) && !$past(SOFT_RESET_OUT) |->
    FAN1_SRC_TEMP_OUT == $past(TEMPS_IN.rem1) ||
    FAN1_SRC_TEMP_OUT == $past(TEMPS_IN.rem2) ||
    FAN1_SRC_TEMP_OUT == $past(hot))
    else $error("fan one source is no mapped reading");
  src_two_a: assert property (
    $past(RST_N) && !$past(SOFT_RESET_OUT) |->
    FAN2_SRC_TEMP_OUT == $past(TEMPS_IN.rem1) ||
    FAN2_SRC_TEMP_OUT == $past(TEMPS_IN.rem2) ||
    FAN2_SRC_TEMP_OUT == $past(hot))
    else $error("fan two source is no mapped reading");
  sw_duty_a: assert property (
    SW_DUTY_OUT |-> !SW_RPM_OUT && !AUTO_CTRL_OUT)
    else $error("duty mode overlaps another mode");
  sw_rpm_a: assert property (
    SW_RPM_OUT |-> !AUTO_CTRL_OUT)
    else $error("rpm mode while automatic");
  srst_reload_a: assert property (
    SOFT_RESET_OUT |=> !SOFT_RESET_OUT && AUTO_CTRL_OUT && !MONITOR_EN_OUT &&
    !SENSE_ANALOG_OUT ##1 ALERT_OUT_N)
    else $error("soft reset did not reload");
  sda_low_a: assert property (SDA_OUT == 1'b0)
    else $error("data pin driven high");
  sda_edge_a: assert property ($changed(SDA_OE) |-> !SCL_IN)
    else $error("data pin moved while bus clock high");
endmodule

bind fmc_regs fmc_regs_chk u_fmc_regs_chk (.MCLK, .RST_N, .SCL_IN, .SDA_OUT,
  .SDA_OE, .TEMPS_IN, .TACH_PIN_IN, .TACH_PULSE_OUT, .MONITOR_EN_OUT,
  .SENSE_ANALOG_OUT, .AUTO_CTRL_OUT, .SW_DUTY_OUT, .SW_RPM_OUT,
  .FAN1_SRC_TEMP_OUT, .FAN2_SRC_TEMP_OUT, .SOFT_RESET_OUT, .ALERT_OUT_N);

// ==== test/fmc_host.sv ====
module fmc_host
  import fmc_pkg::*;
(
  // clock
  input  wire logic clk,
  // slave pull-down on data
  input  wire logic sda_oe,
  // bus lines
  output logic      scl,
  output logic      sda
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int Q = 6; // cycles per bus phase
  logic sda_m;          // master drive, 1 = released
  // pulled-up wire, low if either side pulls
  assign sda = sda_m & ~sda_oe;
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end
  task automatic hold();
    repeat (Q) @(negedge clk);
  endtask
  // one bit, data changes only while clock low
  task automatic bitx(input logic b, output logic r);
    sda_m = b;
    hold();
    scl = 1'b1;
    hold();
    r = sda;
    scl = 1'b0;
    hold();
  endtask
  // start or repeated start
  task automatic start_c();
    sda_m = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sda_m = 1'b0;
    hold();
    scl = 1'b0;
    hold();
  endtask
  task automatic stop_c();
    sda_m = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda_m = 1'b1;
    hold();
  endtask
  // byte msb first, ninth clock released
  task automatic xfer(input logic [7:0] d, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] a,
                    input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       k1, k2, k3;
    start_c();
    xfer({dev, 1'b0}, q, k1);
    xfer(a, q, k2);
    xfer(d, q, k3);
    stop_c();
    ok = k1 & k2 & k3;
  endtask
  // pointer write, repeated start, one byte, no ack
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] q;
    logic       k;
    start_c();
    xfer({SMB_DEV_ADDR, 1'b0}, q, k);
    xfer(a, q, k);
    start_c();
    xfer({SMB_DEV_ADDR, 1'b1}, q, k);
    xfer(8'hff, d, k);
    stop_c();
  endtask
endmodule

// ==== test/fmc_regs_tb.sv ====
module fmc_regs_tb
  import fmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       MCLK, RST_N, scl, sda, sda_oe, sda_out, mon_done, dio_done;
  logic       fan2_fault, mon_en, sense_an, auto_ctrl, sw_duty, sw_rpm;
  logic       srst, alert_n, fail_n;
  fmc_cond_t  cond;
  fmc_temps_t temps;
  logic [1:0] dio_fault, pwm_raw, pwm_pin, tach_pin, tach_out;
  logic [7:0] src1, src2;
  int         err_count, tests_run;

  always #2.5 MCLK = ~MCLK;

  fmc_regs u_fmc_regs (.MCLK(MCLK), .RST_N(RST_N), .SCL_IN(scl),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .MON_CYCLE_DONE(mon_done), .COND_IN(cond), .FAN2_FAULT_IN(fan2_fault),
    .DIODE_CHECK_DONE(dio_done), .DIODE_FAULT_IN(dio_fault),
    .TEMPS_IN(temps), .PWM_RAW_IN(pwm_raw), .PWM_PIN_OUT(pwm_pin),
    .TACH_PIN_IN(tach_pin), .TACH_PULSE_OUT(tach_out),
    .MONITOR_EN_OUT(mon_en), .SENSE_ANALOG_OUT(sense_an),
    .AUTO_CTRL_OUT(auto_ctrl), .SW_DUTY_OUT(sw_duty), .SW_RPM_OUT(sw_rpm),
    .FAN1_SRC_TEMP_OUT(src1), .FAN2_SRC_TEMP_OUT(src2),
    .SOFT_RESET_OUT(srst), .ALERT_OUT_N(alert_n), .FAN_FAIL_OUT_N(fail_n));
  fmc_host u_fmc_host (.clk(MCLK), .sda_oe(sda_oe), .scl(scl), .sda(sda));

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    if (err_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    u_fmc_host.wr(SMB_DEV_ADDR, a, d, ok);
    check("write ack", ok, 1'b1);
  endtask
  task automatic rdc(input string what, input logic [7:0] a,
                     input logic [7:0] exp);
    logic [7:0] d;
    u_fmc_host.rd(a, d);
    check(what, d, exp);
  endtask
  // one monitoring cycle with given results
  task automatic mon(input logic [6:0] c);
    cond     = c;
    mon_done = 1'b1;
    @(negedge MCLK);
    mon_done = 1'b0;
    repeat (3) @(negedge MCLK);
  endtask

  task automatic t_reset();
    logic ok;
    check("outs", {alert_n, fail_n, auto_ctrl, mon_en, srst}, 5'h1c);
    // fan two fault reaches the failure pin, enabled from reset
    fan2_fault = 1'b1;
    repeat (2) @(negedge MCLK);
    check("fan two fail", fail_n, 1'b0);
    fan2_fault = 1'b0;
    repeat (2) @(negedge MCLK);
    check("fan two clear", fail_n, 1'b1);
    rdc("cfg1", OFS_CFG_ONE, RST_CFG_ONE);
    rdc("cfg2", OFS_CFG_TWO, RST_CFG_TWO);
    wr(OFS_STAT_ONE, 8'hff);
    rdc("status", OFS_STAT_ONE, RST_STAT_ONE);
    rdc("unmapped", 8'h07, RD_UNMAPPED);
    u_fmc_host.wr(7'h2d, OFS_CFG_ONE, 8'h00, ok);
    check("foreign ack", ok, 1'b0);
  endtask
  task automatic t_cfg1();
    logic [15:0] exp_src [4] = '{16'h10f0, 16'h1010, 16'hf0f0, 16'h2020};
    for (int m = 0; m < 4; m++) begin
      wr(OFS_CFG_ONE, {1'b1, m[1:0], 5'h00});
      check("src", {src1, src2}, exp_src[m]);
    end
    wr(OFS_CFG_ONE, 8'h0d);
    check("duty", {auto_ctrl, sw_duty, sw_rpm, mon_en, sense_an}, 5'h0b);
    check("pwm inv", pwm_pin, 2'b10);
    wr(OFS_CFG_ONE, 8'h60);
    check("rpm", {auto_ctrl, sw_duty, sw_rpm}, 3'b001);
  endtask
  task automatic t_pins();
    wr(OFS_CFG_ONE, 8'h01);
    wr(OFS_CFG_TWO, 8'h06);
    pwm_raw  = 2'b11;
    tach_pin = 2'b11;
    repeat (5) @(negedge MCLK);
    check("pwm en", pwm_pin, 2'b10);
    check("tach en", tach_out, 2'b01);
    rdc("cfg2 back", OFS_CFG_TWO, 8'h06);
    wr(OFS_CFG_ONE, 8'h05);
    check("analog", {sense_an, tach_out}, 3'b100);
  endtask
  task automatic t_status();
    wr(OFS_CFG_TWO, RST_CFG_TWO);
    wr(OFS_CFG_ONE, 8'h00);
    mon(7'h7f);
    rdc("idle", OFS_STAT_ONE, 8'h00);
    wr(OFS_CFG_ONE, 8'h03);
    mon(7'h7f);
    check("alert", alert_n, 1'b0);
    rdc("flags", OFS_STAT_ONE, 8'hdf);
    mon(7'h7f);
    rdc("again", OFS_STAT_ONE, 8'hde);
    mon(7'h00);
    rdc("clear", OFS_STAT_ONE, 8'h00);
    check("alert off", alert_n, 1'b1);
    wr(OFS_CFG_ONE, 8'h01);
    mon(7'h7f);
    check("alert gate", {alert_n, fail_n}, 2'b11);
    wr(OFS_CFG_ONE, 8'h11);
    check("fail pin", fail_n, 1'b0);
    rdc("rearm", OFS_STAT_ONE, 8'hdf);
  endtask
  task automatic t_diode();
    dio_fault = 2'b11;
    dio_done  = 1'b1;
    @(negedge MCLK);
    dio_done = 1'b0;
    repeat (2) @(negedge MCLK);
    rdc("cfg2 diode", OFS_CFG_TWO, 8'h1f);
    rdc("diode", OFS_STAT_ONE, 8'h20);
    rdc("diode kept", OFS_STAT_ONE, 8'h20);
    // diode flag pending, remote one enable cleared by the check
    wr(OFS_CFG_ONE, 8'h13);
    check("r1 masked", alert_n, 1'b1);
    wr(OFS_CFG_TWO, 8'h3f);
    check("r1 alert", alert_n, 1'b0);
    wr(OFS_CFG_TWO, 8'h80);
    rdc("cfg2 srst", OFS_CFG_TWO, RST_CFG_TWO);
    rdc("cfg1 srst", OFS_CFG_ONE, RST_CFG_ONE);
    rdc("stat srst", OFS_STAT_ONE, 8'h00);
  endtask

  // everything driven from time zero
  initial begin
    MCLK       = 1'b0;
    RST_N      = 1'b0;
    mon_done   = 1'b0;
    dio_done   = 1'b0;
    fan2_fault = 1'b0;
    cond       = '0;
    dio_fault  = 2'b00;
    pwm_raw    = 2'b01;
    tach_pin   = 2'b00;
    temps      = {8'h20, 8'h10, 8'hf0};
    err_count  = 0;
    tests_run  = 0;
    repeat (8) @(negedge MCLK);
    RST_N = 1'b1;
    repeat (4) @(negedge MCLK);
    t_reset();
    t_cfg1();
    t_pins();
    t_status();
    t_diode();
    results();
  end
  // hang guard, about four times the expected run
  initial begin
    #400000;
    err_count++;
    results();
  end
endmodule
